// ===== core/hap_ctl_end.sv
`default_nettype none
// =====================================================
// group controller end: sends polls, reports responses
module hap_ctl_end #(
	parameter int CLKS_PER_BIT = hap_pkg::CLKS_PER_BIT
) (
	input wire logic ref_clk,
	input wire logic reset,
	hap_link_if.ctl link,
	input wire logic send,
	input wire logic send_two,
	input wire logic [7:0] send_addr1,
	input wire logic [7:0] send_addr2,
	input wire logic [7:0] send_ctl,
	input wire logic send_cmd_en,
	input wire logic [7:0] send_cmd,
	output logic busy,
	output logic resp_valid,
	output logic [7:0] resp_data,
	output logic resp_end,
	output logic resp_ok
);
	typedef struct packed {
		logic two;
		logic [7:0] a1;
		logic [7:0] a2;
		logic [7:0] ctl;
		logic cmd_en;
		logic [7:0] cmd;
		hap_pkg::hap_fld_t fld;
		logic busy;
		logic seen;
		logic start;
		logic rv;
		logic [7:0] rd;
		logic re;
		logic rok;
	} hap_ctl_st_t;
	hap_ctl_st_t s;
	hap_ctl_st_t next_s;
	logic [7:0] tx_data;
	logic tx_last;
	logic tx_take;
	logic tx_busy;
	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_end;
	logic rx_ok;

	hap_hdlc_phy #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_phy (
		.ref_clk(ref_clk),
		.reset(reset),
		.tx_start(s.start),
		.tx_data(tx_data),
		.tx_last(tx_last),
		.tx_take(tx_take),
		.tx_busy(tx_busy),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.rx_end(rx_end),
		.rx_ok(rx_ok),
		.ser_out(link.ctl_bit),
		.ser_out_en(link.ctl_en),
		.ser_in(link.dev_bit),
		.ser_in_en(link.dev_en)
	);

	// a repeated poll instead of an ack asks for retransmission
	assign tx_data = (s.fld == hap_pkg::FLD_A1) ? s.a1 : (s.fld == hap_pkg::FLD_A2) ? s.a2 :
		(s.fld == hap_pkg::FLD_CTL) ? s.ctl : s.cmd;
	assign tx_last = (s.fld == hap_pkg::FLD_BODY) || (s.fld == hap_pkg::FLD_CTL && !s.cmd_en);
	assign busy = s.busy;
	assign resp_valid = s.rv;
	assign resp_data = s.rd;
	assign resp_end = s.re;
	assign resp_ok = s.rok;

	// frame launch, field walk and response reporting
	always_comb begin
		next_s = s;
		next_s.start = 1'b0;
		next_s.rv = rx_valid;
		next_s.rd = rx_data;
		next_s.re = rx_end;
		next_s.rok = rx_ok;
		if (send && !s.busy) begin
			next_s = '{two: send_two, a1: send_addr1, a2: send_addr2, ctl: send_ctl, cmd_en: send_cmd_en,
				cmd: send_cmd, fld: hap_pkg::FLD_A1, busy: 1'b1, seen: 1'b0, start: 1'b1,
				rv: rx_valid, rd: rx_data, re: rx_end, rok: rx_ok};
		end
		if (tx_take) begin
			case (s.fld)
			hap_pkg::FLD_A1: next_s.fld = s.two ? hap_pkg::FLD_A2 : hap_pkg::FLD_CTL;
			hap_pkg::FLD_A2: next_s.fld = hap_pkg::FLD_CTL;
			default: next_s.fld = hap_pkg::FLD_BODY;
			endcase
		end
		if (s.busy) begin
			next_s.seen = s.seen | tx_busy;
			if (s.seen && !tx_busy) begin
				next_s.busy = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// ===== core/hap_dev_end.sv
// The address-and-strobe port and the register offsets were left to the implementer.
`default_nettype none
// =====================================================
// auto mode responder: answers controller polls
module hap_dev_end #(
	parameter int CLKS_PER_BIT = hap_pkg::CLKS_PER_BIT,
	parameter int TXQ_DEPTH = hap_pkg::TXQ_DEPTH,
	parameter int RXQ_DEPTH = hap_pkg::RXQ_DEPTH
) (
	input wire logic ref_clk,
	input wire logic reset,
	hap_link_if.dev link,
	input wire logic [2:0] cpu_addr,
	input wire logic [7:0] cpu_wdata,
	input wire logic cpu_wr,
	input wire logic cpu_rd,
	output logic [7:0] cpu_rdata
);
	localparam int TW = $clog2(TXQ_DEPTH);
	localparam int RW = $clog2(RXQ_DEPTH);
	localparam logic [TW:0] TX_FULL = (TW + 1)'(TXQ_DEPTH);
	localparam logic [TW:0] TX_FREE = (TW + 1)'(TXQ_DEPTH - hap_pkg::TXQ_BLOCK);
	localparam logic [RW:0] RX_FULL = (RW + 1)'(RXQ_DEPTH);
	typedef struct packed {
		logic [TXQ_DEPTH-1:0][7:0] txq;
		logic [TW-1:0] trd;
		logic [TW:0] tcnt;
		logic [TW:0] wk;
		logic [RXQ_DEPTH-1:0][7:0] rxq;
		logic [RW-1:0] rrd;
		logic [RW:0] rcnt;
		logic auto_repeat_enable;
		logic two;
		logic dd;
		logic pd;
		logic me;
		logic wait_ack;
		logic rx_data_overflow;
		logic resp;
		logic seen;
		logic start;
		logic aok;
		logic cmd_seen;
		logic store;
		logic [7:0] tx_address_byte_one;
		logic [7:0] tx_address_byte_two;
		logic [7:0] rctl;
		logic [7:0] rcmd;
		logic [7:0] rdata;
		logic [2:0] interrupt_status_register;
		logic [2:0] ri;
		hap_pkg::hap_resp_t kind;
		hap_pkg::hap_fld_t fld;
	} hap_dev_st_t;
	hap_dev_st_t s;
	hap_dev_st_t next_s;
	logic [7:0] tx_data;
	logic tx_last;
	logic tx_take;
	logic tx_busy;
	logic rx_valid;
	logic [7:0] rx_data;
	logic rx_end;
	logic rx_ok;
	logic want;
	hap_pkg::hap_resp_t want_kind;
	logic [2:0] ctl_i;
	logic [TW:0] remain;
	logic [7:0] ctrl_byte;
	logic push;

	hap_hdlc_phy #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_phy (
		.ref_clk(ref_clk),
		.reset(reset),
		.tx_start(s.start),
		.tx_data(tx_data),
		.tx_last(tx_last),
		.tx_take(tx_take),
		.tx_busy(tx_busy),
		.rx_valid(rx_valid),
		.rx_data(rx_data),
		.rx_end(rx_end),
		.rx_ok(rx_ok),
		.ser_out(link.dev_bit),
		.ser_out_en(link.dev_en),
		.ser_in(link.ctl_bit),
		.ser_in_en(link.ctl_en)
	);

	// =====================================================
	// response byte source, walked by the framer's take pulses
	assign ctl_i = s.two ? 3'h2 : 3'h1;
	assign remain = s.tcnt - s.wk;
	assign ctrl_byte = {2'h2, 1'b1, s.auto_repeat_enable, 2'h0, ~s.rx_data_overflow, 1'b1};
	always_comb begin
		case (s.fld)
		hap_pkg::FLD_A1: tx_data = s.tx_address_byte_one;
		hap_pkg::FLD_A2: tx_data = s.tx_address_byte_two;
		hap_pkg::FLD_CTL: tx_data = (s.kind == hap_pkg::RESP_RR) ? hap_pkg::CTL_RR_RESP : hap_pkg::CTL_INFO;
		default: tx_data = (s.kind == hap_pkg::RESP_CTRL) ? ctrl_byte : s.txq[TW'(s.trd + s.wk[TW-1:0])];
		endcase
	end
	assign tx_last = (s.fld == hap_pkg::FLD_CTL) ?
		(s.kind == hap_pkg::RESP_RR || (s.kind == hap_pkg::RESP_IDATA && remain == '0)) :
		(s.fld == hap_pkg::FLD_BODY && (s.kind == hap_pkg::RESP_CTRL || remain == (TW + 1)'(1)));
	assign cpu_rdata = s.rdata;

	// =====================================================
	// register port, receive parsing and response decisions
	always_comb begin
		next_s = s;
		next_s.start = 1'b0;
		next_s.rdata = 8'h00;
		want = 1'b0;
		want_kind = hap_pkg::RESP_RR;
		push = 1'b0;
		// processor writes
		if (cpu_wr) begin
			case (cpu_addr)
			hap_pkg::REG_CMD: begin
				if (cpu_wdata[hap_pkg::CMD_DD]) begin
					next_s.dd = 1'b1;
					next_s.wait_ack = 1'b0;
				end
				if (cpu_wdata[hap_pkg::CMD_PD]) begin
					next_s.pd = 1'b1;
				end
				if (cpu_wdata[hap_pkg::CMD_ME]) begin
					next_s.me = 1'b1;
				end
			end
			hap_pkg::REG_CFG: begin
				next_s.auto_repeat_enable = cpu_wdata[hap_pkg::CFG_AUTO_REPEAT_ENABLE];
				next_s.two = cpu_wdata[hap_pkg::CFG_TWO];
			end
			hap_pkg::REG_TX_ADDRESS_BYTE_ONE: next_s.tx_address_byte_one = cpu_wdata;
			hap_pkg::REG_TX_ADDRESS_BYTE_TWO: next_s.tx_address_byte_two = cpu_wdata;
			hap_pkg::REG_TXQ: if (s.tcnt < TX_FULL) begin
				next_s.txq[TW'(s.trd + s.tcnt[TW-1:0])] = cpu_wdata;
				next_s.tcnt = s.tcnt + (TW + 1)'(1);
			end
			default: next_s.tcnt = s.tcnt;
			endcase
		end
		// processor reads, data stands one cycle later
		if (cpu_rd) begin
			case (cpu_addr)
			hap_pkg::REG_CFG: begin
				next_s.rdata[hap_pkg::CFG_AUTO_REPEAT_ENABLE] = s.auto_repeat_enable;
				next_s.rdata[hap_pkg::CFG_TWO] = s.two;
			end
			hap_pkg::REG_TX_ADDRESS_BYTE_ONE: next_s.rdata = s.tx_address_byte_one;
			hap_pkg::REG_TX_ADDRESS_BYTE_TWO: next_s.rdata = s.tx_address_byte_two;
			hap_pkg::REG_RXQ: begin
				next_s.rdata = s.rxq[s.rrd];
				if (s.rcnt != '0) begin
					next_s.rrd = s.rrd + RW'(1);
					next_s.rcnt = s.rcnt - (RW + 1)'(1);
				end
			end
			hap_pkg::REG_STATUS: begin
				next_s.rdata = {6'(s.rcnt), s.rx_data_overflow, s.tcnt <= TX_FREE};
				next_s.rx_data_overflow = 1'b0;
			end
			hap_pkg::REG_INTERRUPT_STATUS_REGISTER: begin
				next_s.rdata = {5'h00, s.interrupt_status_register};
				next_s.interrupt_status_register = 3'h0;
			end
			default: next_s.rdata = 8'h00;
			endcase
		end
		// framer walks the response fields
		if (tx_take) begin
			case (s.fld)
			hap_pkg::FLD_A1: next_s.fld = s.two ? hap_pkg::FLD_A2 : hap_pkg::FLD_CTL;
			hap_pkg::FLD_A2: next_s.fld = hap_pkg::FLD_CTL;
			hap_pkg::FLD_CTL: next_s.fld = hap_pkg::FLD_BODY;
			default: if (s.kind == hap_pkg::RESP_IDATA) begin
				if (s.auto_repeat_enable) begin
					next_s.wk = s.wk + (TW + 1)'(1);
				end else begin
					// streaming frees the queue as bytes leave
					next_s.trd = s.trd + TW'(1);
					next_s.tcnt = next_s.tcnt - (TW + 1)'(1);
					if (s.tcnt == TX_FREE + (TW + 1)'(1) && !s.me) begin
						next_s.interrupt_status_register[hap_pkg::IS_XPR] = 1'b1;
					end
				end
			end
			endcase
		end
		next_s.seen = s.seen | tx_busy;
		if (s.resp && s.seen && !tx_busy) begin
			next_s.resp = 1'b0;
			next_s.seen = 1'b0;
			if (s.kind == hap_pkg::RESP_IDATA) begin
				next_s.wait_ack = 1'b1;
			end
		end
		// received bytes: address, control, command, data
		if (rx_valid) begin
			if (s.ri == 3'h0) begin
				next_s.aok = (rx_data == s.tx_address_byte_one);
			end
			if (s.ri == 3'h1 && s.two) begin
				next_s.aok = s.aok && (rx_data == s.tx_address_byte_two);
			end
			if (s.ri == ctl_i) begin
				next_s.rctl = rx_data;
			end
			if (s.ri == ctl_i + 3'h1) begin
				next_s.rcmd = rx_data;
				next_s.cmd_seen = 1'b1;
				next_s.store = s.aok && !s.rctl[0] && !hap_pkg::cmd_is_prep(rx_data) &&
					!hap_pkg::cmd_is_ack(rx_data);
			end
			if (s.ri != 3'h7) begin
				next_s.ri = s.ri + 3'h1;
			end
			// the command byte itself is queued on its own verdict, decided in this same cycle
			push = (s.ri == ctl_i + 3'h1) ? next_s.store : (s.ri > ctl_i + 3'h1 && s.store);
			if (push) begin
				if (s.rcnt < RX_FULL) begin
					next_s.rxq[RW'(s.rrd + s.rcnt[RW-1:0])] = rx_data;
					next_s.rcnt = next_s.rcnt + (RW + 1)'(1);
				end else begin
					next_s.rx_data_overflow = 1'b1;
				end
			end
		end
		// end of frame: only polled frames get an answer
		if (rx_end) begin
			next_s.ri = 3'h0;
			next_s.aok = 1'b0;
			next_s.cmd_seen = 1'b0;
			next_s.store = 1'b0;
			if (s.store) begin
				next_s.interrupt_status_register[hap_pkg::IS_RME] = 1'b1;
			end
			if (rx_ok && s.aok && s.ri > ctl_i) begin
				if (!s.rctl[0]) begin
					want = s.rctl[4];
					want_kind = hap_pkg::RESP_CTRL;
					if (s.cmd_seen && hap_pkg::cmd_is_prep(s.rcmd) && s.pd) begin
						want_kind = hap_pkg::RESP_IDATA;
					end
					if (s.cmd_seen && hap_pkg::cmd_is_ack(s.rcmd)) begin
						next_s.interrupt_status_register[hap_pkg::IS_XPR] = 1'b1;
						next_s.trd = '0;
						next_s.tcnt = '0;
						next_s.pd = 1'b0;
						next_s.me = 1'b0;
						next_s.wait_ack = 1'b0;
					end
				end else if (s.rctl[4:0] == hap_pkg::RR_POLL) begin
					want = 1'b1;
					if (s.dd && s.wait_ack && !s.auto_repeat_enable) begin
						// frame already left the queue: processor must reload
						next_s.interrupt_status_register[hap_pkg::IS_XMR] = 1'b1;
						next_s.dd = 1'b0;
						next_s.wait_ack = 1'b0;
						next_s.trd = '0;
						next_s.tcnt = '0;
					end else if (s.dd) begin
						want_kind = hap_pkg::RESP_IDATA;
					end
				end else if (s.rctl[1:0] == hap_pkg::RR_TYPE && !s.rctl[4]) begin
					next_s.interrupt_status_register[hap_pkg::IS_XPR] = 1'b1;
					next_s.trd = '0;
					next_s.tcnt = '0;
					next_s.dd = 1'b0;
					next_s.me = 1'b0;
					next_s.wait_ack = 1'b0;
				end
			end
		end
		// polls arriving mid-response are dropped
		if (want && !s.resp) begin
			next_s.resp = 1'b1;
			next_s.seen = 1'b0;
			next_s.start = 1'b1;
			next_s.kind = want_kind;
			next_s.fld = hap_pkg::FLD_A1;
			next_s.wk = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// ===== core/hap_hdlc_phy.sv
`default_nettype none
// =====================================================
// bit level framer: flags, zero insertion, FCS both ways
module hap_hdlc_phy #(
	parameter int CLKS_PER_BIT = hap_pkg::CLKS_PER_BIT
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic tx_start,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	output logic tx_take,
	output logic tx_busy,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_end,
	output logic rx_ok,
	output logic ser_out,
	output logic ser_out_en,
	input wire logic ser_in,
	input wire logic ser_in_en
);
	typedef struct packed {
		logic [7:0] div;
		hap_pkg::hap_tx_state_t tst;
		logic [15:0] sh;
		logic [3:0] bitn;
		logic [2:0] ones;
		logic [15:0] crc;
		logic last;
		logic take;
		logic obit;
		logic oen;
		logic inf;
		logic [2:0] rones;
		logic [2:0] rbit;
		logic [7:0] rsh;
		logic [15:0] rcrc;
		logic [15:0] rcrc_b;
		logic [7:0] h0;
		logic [7:0] h1;
		logic [1:0] nb;
		logic rv;
		logic [7:0] rd;
		logic re;
		logic rok;
	} hap_phy_st_t;
	hap_phy_st_t s;
	hap_phy_st_t next_s;
	logic tick;
	logic stuff;
	logic [15:0] tx_nc;
	logic [15:0] rx_nc;
	logic [7:0] rx_byte;

	// bit rate enable from a free divider
	assign tick = (s.div == 8'(CLKS_PER_BIT - 1));
	assign stuff = s.ones == 3'h5 && (s.tst == hap_pkg::TX_DATA || s.tst == hap_pkg::TX_FCS ||
		(s.tst == hap_pkg::TX_CLOSE && s.bitn == 4'h0));
	assign tx_nc = hap_pkg::crc_bit(s.crc, s.sh[0]);
	assign rx_nc = hap_pkg::crc_bit(s.rcrc, ser_in);
	assign rx_byte = {ser_in, s.rsh[7:1]};
	assign tx_take = s.take;
	assign tx_busy = (s.tst != hap_pkg::TX_IDLE);
	assign ser_out = s.obit;
	assign ser_out_en = s.oen;
	assign rx_valid = s.rv;
	assign rx_data = s.rd;
	assign rx_end = s.re;
	assign rx_ok = s.rok;

	// transmit serialiser and receive deframer
	always_comb begin
		next_s = s;
		next_s.div = tick ? 8'h00 : s.div + 8'h01;
		next_s.take = 1'b0;
		next_s.oen = 1'b0;
		next_s.rv = 1'b0;
		next_s.re = 1'b0;
		if (s.tst == hap_pkg::TX_IDLE) begin
			if (tx_start) begin
				next_s.tst = hap_pkg::TX_OPEN;
				next_s.sh = {8'h00, hap_pkg::FLAG};
				next_s.bitn = 4'h0;
				next_s.crc = hap_pkg::CRC_INIT;
			end
		end else if (tick) begin
			next_s.oen = 1'b1;
			if (stuff) begin
				next_s.obit = 1'b0;
				next_s.ones = 3'h0;
			end else begin
				next_s.obit = s.sh[0];
				next_s.sh = {1'b0, s.sh[15:1]};
				next_s.bitn = s.bitn + 4'h1;
				next_s.ones = s.sh[0] ? s.ones + 3'h1 : 3'h0;
				if (s.tst == hap_pkg::TX_DATA) begin
					next_s.crc = tx_nc;
				end
				case (s.tst)
				hap_pkg::TX_OPEN: if (s.bitn == 4'h7) begin
					next_s.tst = hap_pkg::TX_DATA;
					next_s.sh = {8'h00, tx_data};
					next_s.bitn = 4'h0;
					next_s.ones = 3'h0;
					next_s.take = 1'b1;
					next_s.last = tx_last;
				end
				hap_pkg::TX_DATA: if (s.bitn == 4'h7) begin
					next_s.bitn = 4'h0;
					if (s.last) begin
						next_s.tst = hap_pkg::TX_FCS;
						next_s.sh = ~tx_nc;
					end else begin
						next_s.sh = {8'h00, tx_data};
						next_s.take = 1'b1;
						next_s.last = tx_last;
					end
				end
				hap_pkg::TX_FCS: if (s.bitn == 4'hF) begin
					next_s.tst = hap_pkg::TX_CLOSE;
					next_s.sh = {8'h00, hap_pkg::FLAG};
					next_s.bitn = 4'h0;
				end
				hap_pkg::TX_CLOSE: if (s.bitn == 4'h7) begin
					next_s.tst = hap_pkg::TX_IDLE;
				end
				default: next_s.tst = hap_pkg::TX_IDLE;
				endcase
			end
		end
		// receive: a flag closes one frame and opens the next
		if (ser_in_en) begin
			if (ser_in) begin
				next_s.rones = (s.rones == 3'h7) ? 3'h7 : s.rones + 3'h1;
				if (s.rones == 3'h6) begin
					next_s.inf = 1'b0; // abort
				end
			end else begin
				next_s.rones = 3'h0;
			end
			if (ser_in ? s.rones < 3'h6 : s.rones != 3'h5 && s.rones != 3'h6) begin
				if (s.inf) begin
					next_s.rsh = rx_byte;
					next_s.rbit = s.rbit + 3'h1;
					next_s.rcrc = rx_nc;
					if (s.rbit == 3'h7) begin
						// two bytes are held back so the FCS never leaves
						next_s.rcrc_b = rx_nc;
						next_s.h0 = rx_byte;
						next_s.h1 = s.h0;
						next_s.nb = (s.nb == 2'h3) ? 2'h3 : s.nb + 2'h1;
						next_s.rv = (s.nb >= 2'h2);
						next_s.rd = s.h1;
					end
				end
			end else if (!ser_in && s.rones == 3'h6) begin
				next_s.re = s.inf && s.rbit == 3'h7 && s.nb >= 2'h2;
				next_s.rok = (s.rcrc_b == hap_pkg::CRC_GOOD);
				next_s.inf = 1'b1;
				next_s.rbit = 3'h0;
				next_s.nb = 2'h0;
				next_s.rcrc = hap_pkg::CRC_INIT;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// ===== core/hap_link_if.sv
`default_nettype none
// =====================================================
// serial link: one data bit per enable pulse each way
interface hap_link_if;
	logic ctl_bit;
	logic ctl_en;
	logic dev_bit;
	logic dev_en;
	modport dev (input ctl_bit, input ctl_en, output dev_bit, output dev_en);
	modport ctl (output ctl_bit, output ctl_en, input dev_bit, input dev_en);
endinterface
`default_nettype wire

// ===== core/hap_pkg.sv
// Behaviour
// - RR poll with direct data sends I-frame
// - RR poll without direct data sends RR-response
// - RR-response is address, control 11h, FCS
// - address from address byte one, two if wide
// - control response is address, 10h, one byte
// - response byte 1,0,1,repeat,0,0,not-overflow,1
// - data I-frame is address, 10h, queue bytes
// - Ax command sends prepared data else control response
// - other I-frames queued, message end, control response
// - processor checks writable, loads 32, stores 64
// - pool ready when processor half frees again
// - RR ack flags pool ready, clears queue
// - long messages stream through queue, processor refills
// - controller repeats poll to request retransmission
// - repeat poll without auto repeat flags repeat
// - auto repeat resends short frame unaided
// - processor enables auto repeat for prepared data
// - D0h-EFh command acknowledges, pool ready, queue reset
// - processor loads queue then prepared and end commands
// - transmit only after a polled RR or I-frame
// - RR poll is control pattern xxx10001
`default_nettype none
package hap_pkg;
	// =====================================================
	// sizes and timing
	localparam int CLKS_PER_BIT = 4;
	localparam int TXQ_DEPTH = 64;
	localparam int TXQ_BLOCK = 32;
	localparam int RXQ_DEPTH = 32;
	// =====================================================
	// frame constants
	localparam logic [7:0] FLAG = 8'h7E;
	localparam logic [7:0] CTL_RR_RESP = 8'h11;
	localparam logic [7:0] CTL_INFO = 8'h10;
	localparam logic [4:0] RR_POLL = 5'h11;
	localparam logic [1:0] RR_TYPE = 2'h1;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h8408;
	localparam logic [15:0] CRC_GOOD = 16'hF0B8;
	// =====================================================
	// processor register map and bit positions
	localparam logic [2:0] REG_CMD = 3'h0;
	localparam logic [2:0] REG_CFG = 3'h1;
	localparam logic [2:0] REG_TX_ADDRESS_BYTE_ONE = 3'h2;
	localparam logic [2:0] REG_TX_ADDRESS_BYTE_TWO = 3'h3;
	localparam logic [2:0] REG_TXQ = 3'h4;
	localparam logic [2:0] REG_RXQ = 3'h5;
	localparam logic [2:0] REG_STATUS = 3'h6;
	localparam logic [2:0] REG_INTERRUPT_STATUS_REGISTER = 3'h7;
	localparam int CMD_DD = 0;
	localparam int CMD_PD = 1;
	localparam int CMD_ME = 2;
	localparam int CFG_AUTO_REPEAT_ENABLE = 0;
	localparam int CFG_TWO = 1;
	localparam int IS_XPR = 0;
	localparam int IS_XMR = 1;
	localparam int IS_RME = 2;
	// =====================================================
	// types
	typedef enum logic [2:0] {TX_IDLE, TX_OPEN, TX_DATA, TX_FCS, TX_CLOSE} hap_tx_state_t;
	typedef enum logic [1:0] {FLD_A1, FLD_A2, FLD_CTL, FLD_BODY} hap_fld_t;
	typedef enum logic [1:0] {RESP_RR, RESP_CTRL, RESP_IDATA} hap_resp_t;
	// =====================================================
	// helpers
	function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
		crc_bit = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
	endfunction
	function automatic logic cmd_is_prep(input logic [7:0] b);
		cmd_is_prep = (b[7:4] == 4'hA);
	endfunction
	function automatic logic cmd_is_ack(input logic [7:0] b);
		cmd_is_ack = (b >= 8'hD0) && (b <= 8'hEF);
	endfunction
endpackage
`default_nettype wire

// ===== testbench/hap_checker.sv
`default_nettype none
// =====================================================
// link watcher: framing and turn taking on both wires
module hap_checker (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic ctl_bit,
	input wire logic ctl_en,
	input wire logic dev_bit,
	input wire logic dev_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] dev_ones;
	logic [3:0] ctl_ones;
	logic [3:0] dev_idle;
	logic [7:0] ctl_gap;
	logic dev_start;
	logic ctl_start;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	// =====================================================
	// helpers: runs of ones, idle time since the last bit
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dev_ones <= 4'h0;
			ctl_ones <= 4'h0;
			dev_idle <= 4'hF;
			ctl_gap <= 8'hFF;
		end else begin
			if (dev_en) dev_ones <= dev_bit ? dev_ones + 4'h1 : 4'h0;
			if (ctl_en) ctl_ones <= ctl_bit ? ctl_ones + 4'h1 : 4'h0;
			dev_idle <= dev_en ? 4'h0 : ((dev_idle == 4'hF) ? 4'hF : dev_idle + 4'h1);
			ctl_gap <= ctl_en ? 8'h00 : ((ctl_gap == 8'hFF) ? 8'hFF : ctl_gap + 8'h01);
		end
	end
	// a long silence before a bit marks the opening flag
	assign dev_start = dev_en && (dev_idle > 4'h8);
	assign ctl_start = ctl_en && (ctl_gap > 8'h08);
	// =====================================================
	// properties
	property p_dev_spacing;
		dev_en |=> !dev_en [*3];
	endproperty
	a_dev_spacing: assert property (p_dev_spacing) else $error("device bits too close");
	property p_ctl_spacing;
		ctl_en |=> !ctl_en [*3];
	endproperty
	a_ctl_spacing: assert property (p_ctl_spacing) else $error("controller bits too close");
	property p_half_duplex;
		dev_en |-> !ctl_en;
	endproperty
	a_half_duplex: assert property (p_half_duplex) else $error("device talks over a poll");
	property p_dev_stuff;
		dev_en |=> dev_ones <= 4'h6;
	endproperty
	a_dev_stuff: assert property (p_dev_stuff) else $error("device run of ones too long");
	property p_ctl_stuff;
		ctl_en |=> ctl_ones <= 4'h6;
	endproperty
	a_ctl_stuff: assert property (p_ctl_stuff) else $error("controller run of ones too long");
	property p_dev_open;
		dev_start |-> !dev_bit ##4 (dev_en && dev_bit);
	endproperty
	a_dev_open: assert property (p_dev_open) else $error("device frame lacks opening flag");
	property p_ctl_open;
		ctl_start |-> !ctl_bit;
	endproperty
	a_ctl_open: assert property (p_ctl_open) else $error("poll lacks opening flag");
	property p_reply_after_poll;
		dev_start |-> ctl_gap < 8'h40;
	endproperty
	a_reply_after_poll: assert property (p_reply_after_poll) else $error("device frame without poll");
	// main scenarios seen
	c_dev_frame: cover property (dev_start);
	c_ctl_frame: cover property (ctl_start);
	c_dev_five: cover property (dev_en && dev_ones == 4'h5);
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] cpu_addr = 3'h0;
	logic [7:0] cpu_wdata = 8'h00;
	logic cpu_wr = 1'b0;
	logic cpu_rd = 1'b0;
	logic [7:0] cpu_rdata;
	logic send = 1'b0;
	logic send_two = 1'b0;
	logic send_cmd_en = 1'b0;
	logic [7:0] send_ctl = 8'h00;
	logic [7:0] send_cmd = 8'h00;
	logic busy;
	logic resp_valid;
	logic resp_end;
	logic resp_ok;
	logic [7:0] resp_data;
	logic [7:0] eq[$];
	int errors = 0;
	int cmp_count = 0;
	hap_link_if link();
	hap_dev_end u_hap_dev_end (.ref_clk(ref_clk), .reset(reset), .link(link.dev), .cpu_addr(cpu_addr),
		.cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata));
	hap_ctl_end u_hap_ctl_end (.ref_clk(ref_clk), .reset(reset), .link(link.ctl), .send(send),
		.send_two(send_two), .send_addr1(8'h5A), .send_addr2(8'hC3), .send_ctl(send_ctl),
		.send_cmd_en(send_cmd_en), .send_cmd(send_cmd), .busy(busy), .resp_valid(resp_valid),
		.resp_data(resp_data), .resp_end(resp_end), .resp_ok(resp_ok));
	hap_checker u_hap_checker (.ref_clk(ref_clk), .reset(reset), .ctl_bit(link.ctl_bit),
		.ctl_en(link.ctl_en), .dev_bit(link.dev_bit), .dev_en(link.dev_en));
	// free running 250 MHz clock
	always #2 ref_clk = ~ref_clk;
	// =====================================================
	// compare, register access and poll tasks
	task automatic chk(input logic [7:0] e, input logic [7:0] g, input string what);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		cpu_addr <= a;
		cpu_wdata <= d;
		cpu_wr <= 1'b1;
		@(posedge ref_clk);
		cpu_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, input logic [7:0] e, input string what);
		@(posedge ref_clk);
		cpu_addr <= a;
		cpu_rd <= 1'b1;
		@(posedge ref_clk);
		cpu_rd <= 1'b0;
		#1 chk(e, cpu_rdata, what);
	endtask
	// i-frames carry a command byte, rr frames none
	task automatic poll(input logic [7:0] c, input logic [7:0] cmd, input logic reply);
		logic [7:0] got[$];
		int n;
		int lim;
		logic ok;
		lim = reply ? 3000 : 700;
		ok = 1'b0;
		@(posedge ref_clk);
		send_ctl <= c;
		send_cmd_en <= ~c[0];
		send_cmd <= cmd;
		send <= 1'b1;
		@(posedge ref_clk);
		send <= 1'b0;
		for (n = 0; n < lim; n++) begin
			@(posedge ref_clk);
			#1;
			if (resp_valid === 1'b1) got.push_back(resp_data);
			if (resp_end === 1'b1) begin
				ok = resp_ok;
				break;
			end
		end
		if (!reply) begin
			chk(8'h00, 8'(got.size()), "unsolicited bytes");
		end else if (n == lim) begin
			errors++;
			$display("ERROR reply expected frame seen none");
			summarize();
		end else begin
			chk(8'h01, {7'h00, ok}, "fcs ok");
			chk(8'(eq.size()), 8'(got.size()), "frame length");
			foreach (eq[i]) chk(eq[i], got[i], "frame byte");
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// =====================================================
	// test sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		reset <= 1'b0;
		wr(hap_pkg::REG_TX_ADDRESS_BYTE_ONE, 8'h5A);
		wr(hap_pkg::REG_TX_ADDRESS_BYTE_TWO, 8'hC3);
		rd(hap_pkg::REG_STATUS, 8'h01, "status");
		rd(hap_pkg::REG_CFG, 8'h00, "cfg");
		eq = {8'h5A, 8'h11};
		poll(8'h11, 8'h00, 1'b1);
		$display("test rr_response done");
		for (int i = 0; i < 3; i++) wr(hap_pkg::REG_TXQ, 8'h30 + 8'(i));
		wr(hap_pkg::REG_CMD, 8'h05);
		eq = {8'h5A, 8'h10, 8'h30, 8'h31, 8'h32};
		poll(8'h11, 8'h00, 1'b1);
		eq = {8'h5A, 8'h11};
		poll(8'h11, 8'h00, 1'b1);
		rd(hap_pkg::REG_INTERRUPT_STATUS_REGISTER, 8'h02, "repeat irq");
		poll(8'h01, 8'h00, 1'b0);
		rd(hap_pkg::REG_INTERRUPT_STATUS_REGISTER, 8'h01, "pool ready irq");
		$display("test direct_data done");
		wr(hap_pkg::REG_CFG, 8'h03);
		rd(hap_pkg::REG_CFG, 8'h03, "cfg");
		wr(hap_pkg::REG_TXQ, 8'h61);
		wr(hap_pkg::REG_TXQ, 8'h62);
		wr(hap_pkg::REG_CMD, 8'h05);
		@(posedge ref_clk) send_two <= 1'b1;
		eq = {8'h5A, 8'hC3, 8'h10, 8'h61, 8'h62};
		poll(8'h11, 8'h00, 1'b1);
		poll(8'h11, 8'h00, 1'b1);
		rd(hap_pkg::REG_INTERRUPT_STATUS_REGISTER, 8'h00, "no repeat irq");
		poll(8'h01, 8'h00, 1'b0);
		rd(hap_pkg::REG_INTERRUPT_STATUS_REGISTER, 8'h01, "pool ready irq");
		$display("test auto_repeat done");
		eq = {8'h5A, 8'hC3, 8'h10, 8'hB3};
		poll(8'h10, 8'h42, 1'b1);
		rd(hap_pkg::REG_INTERRUPT_STATUS_REGISTER, 8'h04, "message end irq");
		rd(hap_pkg::REG_RXQ, 8'h42, "receive queue byte");
		poll(8'h10, 8'hA5, 1'b1);
		wr(hap_pkg::REG_TXQ, 8'h77);
		wr(hap_pkg::REG_CMD, 8'h06);
		eq = {8'h5A, 8'hC3, 8'h10, 8'h77};
		poll(8'h10, 8'hA3, 1'b1);
		poll(8'h00, 8'hD4, 1'b0);
		rd(hap_pkg::REG_INTERRUPT_STATUS_REGISTER, 8'h01, "pool ready irq");
		eq = {8'h5A, 8'hC3, 8'h11};
		poll(8'h11, 8'h00, 1'b1);
		$display("test prepared_data done");
		// streaming without auto repeat: pool ready once the count falls to half (33 to 32)
		wr(hap_pkg::REG_CFG, 8'h02);
		eq = {8'h5A, 8'hC3, 8'h10};
		for (int i = 0; i < 33; i++) begin
			wr(hap_pkg::REG_TXQ, 8'(i));
			eq.push_back(8'(i));
		end
		rd(hap_pkg::REG_STATUS, 8'h00, "status not writable");
		wr(hap_pkg::REG_CMD, 8'h01);
		poll(8'h11, 8'h00, 1'b1);
		rd(hap_pkg::REG_INTERRUPT_STATUS_REGISTER, 8'h01, "pool ready irq");
		$display("test long_message done");
		summarize();
	end
endmodule
`default_nettype wire
